// >>> hw/ddr_init_seq.sv
// Device-side reset, initialization and mode-register write logic with AXI4-Lite access.
// Assumes pins and command clock are asynchronous; the command clock is sampled, not used.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ddr_init_seq #(
  parameter int INIT_CYCLES = ddr_init_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire ddr_init_pkg::pins_t pins,
  output logic termOn,
  output logic devReady,
  output logic burstInterleaved,
  output logic burstChop,
  input wire logic [ddr_init_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ddr_init_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    ddr_init_pkg::pins_t s1;
    ddr_init_pkg::pins_t s2;
    logic clkPrev;
    ddr_init_pkg::init_state_t st;
    logic [15:0] initCnt;
    logic ckeSeen;
    logic ckeEarly;
    logic [3:0] written;
    logic interleaved;
    logic [1:0] burstLength;
    logic chop;
    logic dllEnabled;
    logic dllResetSeen;
    logic calStarted;
    logic [9:0] lockCnt;
    logic [9:0] calCnt;
    logic termOn;
    logic termOff;
    logic mwEn;
    logic [1:0] mwAddr;
    logic [12:0] mwData;
    logic awHeld;
    logic [4:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic [1:0] rdPhase;
    logic [4:0] arAddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ready;
  } state_t;

  state_t q;
  state_t d;
  logic [12:0] memRd;
  ddr_init_pkg::status_t status;

  mode_reg_store store (
    .clk(clk),
    .wrEn(q.mwEn),
    .wrAddr(q.mwAddr),
    .wrData(q.mwData),
    .rdAddr(q.arAddr[3:2]),
    .rdData(memRd)
  );

  function automatic ddr_init_pkg::cmd_t decodeCmd(input ddr_init_pkg::pins_t p);
    ddr_init_pkg::cmd_t c;
    c = ddr_init_pkg::CMD_NONE;
    if (!p.csN) begin
      case ({p.rasN, p.casN, p.weN})
        3'h0: c = ddr_init_pkg::CMD_MODE_WRITE;
        3'h6: c = p.addr[ddr_init_pkg::CAL_LONG_BIT] ? ddr_init_pkg::CMD_CAL
                                                    : ddr_init_pkg::CMD_NONE;
        3'h5: c = ddr_init_pkg::CMD_READ;
        3'h4: c = ddr_init_pkg::CMD_WRITE;
        default: c = ddr_init_pkg::CMD_NONE;
      endcase
    end
    return c;
  endfunction : decodeCmd

  function automatic logic isModeAddr(input logic [4:0] a);
    return a[4:2] >= ddr_init_pkg::MODE_BASE[4:2];
  endfunction : isModeAddr

  always_comb begin
    ddr_init_pkg::cmd_t cmd;
    logic linkEdge;
    cmd = decodeCmd(q.s2);
    linkEdge = q.s2.cmdClk && !q.clkPrev;
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.clkPrev = q.s2.cmdClk;
    d.mwEn = 1'b0;

    status = '0;
    status.burstLength = q.burstLength;
    status.interleaved = q.interleaved;
    status.lastChop = q.chop;
    status.dllResetSeen = q.dllResetSeen;
    status.dllEnabled = q.dllEnabled;
    status.calStarted = q.calStarted;
    status.ready = (q.st == ddr_init_pkg::ST_READY);
    status.written = q.written;
    status.ckeEarly = q.ckeEarly;
    status.ckeSeen = q.ckeSeen;
    status.state = 3'(q.st);

    case (q.st)
      ddr_init_pkg::ST_RESET: begin
        d.initCnt = '0;
        if (q.s2.resetN) begin
          d.st = ddr_init_pkg::ST_INTERNAL_INIT;
        end
      end
      ddr_init_pkg::ST_INTERNAL_INIT: begin
        // Internal init counts the system clock since the command clock may be stopped
        if (q.initCnt == 16'(INIT_CYCLES - 1)) begin
          d.st = ddr_init_pkg::ST_WAIT_CKE;
        end else begin
          d.initCnt = q.initCnt + 16'h1;
        end
        if (linkEdge && q.s2.cke) begin
          d.ckeEarly = 1'b1;
        end
      end
      ddr_init_pkg::ST_WAIT_CKE: begin
        if (linkEdge && q.s2.cke) begin
          d.ckeSeen = 1'b1;
          d.st = ddr_init_pkg::ST_CONFIG;
        end
      end
      ddr_init_pkg::ST_CONFIG, ddr_init_pkg::ST_READY: begin
        if (q.written == 4'hf && q.calStarted && q.lockCnt == '0 && q.calCnt == '0) begin
          d.st = ddr_init_pkg::ST_READY;
        end
      end
      default: d.st = ddr_init_pkg::ST_RESET;
    endcase

    if ((q.st == ddr_init_pkg::ST_CONFIG || q.st == ddr_init_pkg::ST_READY) && linkEdge) begin
      if (q.lockCnt != '0) begin
        d.lockCnt = q.lockCnt - 10'h1;
      end
      if (q.calCnt != '0) begin
        d.calCnt = q.calCnt - 10'h1;
      end
      if (q.s2.cke) begin
        case (cmd)
          ddr_init_pkg::CMD_MODE_WRITE: begin
            // Bank bit 2 high is no mode write; the whole word is replaced
            if (!q.s2.bankSelect[2]) begin
              d.mwEn = 1'b1;
              d.mwAddr = q.s2.bankSelect[1:0];
              d.mwData = q.s2.addr;
              d.written[q.s2.bankSelect[1:0]] = 1'b1;
              // Features take effect at once, well inside the update delay
              d.mwData = q.s2.addr;
              if (q.s2.bankSelect[1:0] == 2'h0) begin
                d.interleaved = q.s2.addr[ddr_init_pkg::BURST_TYPE_BIT];
                d.burstLength = q.s2.addr[1:0];
                if (q.s2.addr[ddr_init_pkg::DLL_RESET_BIT]) begin
                  d.dllResetSeen = 1'b1;
                  d.lockCnt = ddr_init_pkg::DLL_LOCK_CLOCKS;
                end
              end
              if (q.s2.bankSelect[1:0] == 2'h1) begin
                d.dllEnabled = !q.s2.addr[ddr_init_pkg::DLL_DISABLE_BIT];
              end
            end
          end
          ddr_init_pkg::CMD_CAL: begin
            d.calStarted = 1'b1;
            d.calCnt = ddr_init_pkg::CAL_INIT_CLOCKS;
          end
          ddr_init_pkg::CMD_READ, ddr_init_pkg::CMD_WRITE: begin
            case (q.burstLength)
              ddr_init_pkg::BL_FIXED_FOUR: d.chop = 1'b1;
              ddr_init_pkg::BL_ON_THE_FLY:
                d.chop = !q.s2.addr[ddr_init_pkg::CHOP_SELECT_BIT];
              default: d.chop = 1'b0;
            endcase
          end
          default: d.chop = q.chop;
        endcase
      end
    end

    // Termination stays high impedance until clock enable has been registered high
    d.termOn = q.ckeSeen && q.s2.termination_control_input && !q.termOff;

    // Warm reset wipes progress; it overrides the state, counters and store write decoded this cycle, not burst, chop or DLL settings
    if (!q.s2.resetN) begin
      d.st = ddr_init_pkg::ST_RESET;
      d.ckeSeen = 1'b0;
      d.ckeEarly = 1'b0;
      d.written = '0;
      d.calStarted = 1'b0;
      d.dllResetSeen = 1'b0;
      d.lockCnt = '0;
      d.calCnt = '0;
      d.termOn = 1'b0;
      d.mwEn = 1'b0;
    end
    d.ready = (d.st == ddr_init_pkg::ST_READY);

    if (awvalid && q.awready) begin
      d.awHeld = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.wHeld = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.awHeld && q.wHeld && !q.bvalid) begin
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = ddr_init_pkg::RESP_OKAY;
      if (q.awAddr[4:2] == ddr_init_pkg::CTRL_OFFSET[4:2]) begin
        if (q.wStrb[0]) begin
          d.termOff = q.wData[ddr_init_pkg::CTRL_TERM_OFF_BIT];
        end
      end else if (q.awAddr[4:2] != ddr_init_pkg::STATUS_OFFSET[4:2]
                   && q.awAddr[4:2] != ddr_init_pkg::BURST_OFFSET[4:2]
                   && !isModeAddr(q.awAddr)) begin
        d.bresp = ddr_init_pkg::RESP_SLVERR;
      end
    end
    d.awready = !d.awHeld && !d.bvalid;
    d.wready = !d.wHeld && !d.bvalid;

    case (q.rdPhase)
      2'h0: begin
        if (arvalid && q.arready) begin
          d.arAddr = araddr;
          d.arready = 1'b0;
          d.rdPhase = 2'h1;
        end
      end
      2'h1: d.rdPhase = 2'h2;
      2'h2: begin
        // Store output is registered, so the answer waits one extra cycle
        d.rvalid = 1'b1;
        d.rresp = ddr_init_pkg::RESP_OKAY;
        d.rdata = '0;
        d.rdPhase = 2'h3;
        if (q.arAddr[4:2] == ddr_init_pkg::CTRL_OFFSET[4:2]) begin
          d.rdata[ddr_init_pkg::CTRL_TERM_OFF_BIT] = q.termOff;
        end else if (q.arAddr[4:2] == ddr_init_pkg::STATUS_OFFSET[4:2]) begin
          d.rdata = 32'(status);
        end else if (q.arAddr[4:2] == ddr_init_pkg::BURST_OFFSET[4:2]) begin
          d.rdata = {30'h0, q.interleaved, q.chop};
        end else if (isModeAddr(q.arAddr)) begin
          d.rdata = q.written[q.arAddr[3:2]] ? {19'h0, memRd} : 32'h0;
        end else begin
          d.rresp = ddr_init_pkg::RESP_SLVERR;
        end
      end
      default: begin
        if (rready) begin
          d.rvalid = 1'b0;
          d.arready = 1'b1;
          d.rdPhase = 2'h0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= ddr_init_pkg::ST_RESET;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign termOn = q.termOn;
  assign devReady = q.ready;
  assign burstInterleaved = q.interleaved;
  assign burstChop = q.chop;
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
endmodule : ddr_init_seq

// >>> hw/ddr_init_pkg.sv
// Constants, types and register map for the DRAM power-up and mode-set block.
// Assumes one 40 MHz system clock; the pins and the command clock arrive asynchronously.
package ddr_init_pkg;
  localparam int CLK_MHZ = 40;
  localparam int INIT_TIME_US = 500;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam logic [9:0] DLL_LOCK_CLOCKS = 10'h200;
  localparam logic [9:0] CAL_INIT_CLOCKS = 10'h200;

  localparam int ADDR_W = 5;
  localparam logic [4:0] CTRL_OFFSET = 5'h00;
  localparam logic [4:0] STATUS_OFFSET = 5'h04;
  localparam logic [4:0] BURST_OFFSET = 5'h08;
  localparam logic [4:0] MODE_BASE = 5'h10;
  localparam int CTRL_TERM_OFF_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int BURST_TYPE_BIT = 3;
  localparam int DLL_RESET_BIT = 8;
  localparam int DLL_DISABLE_BIT = 0;
  localparam int CHOP_SELECT_BIT = 12;
  localparam int CAL_LONG_BIT = 10;
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BL_FIXED_FOUR = 2'h2;

  typedef enum {ST_RESET, ST_INTERNAL_INIT, ST_WAIT_CKE, ST_CONFIG, ST_READY} init_state_t;
  typedef enum {CMD_NONE, CMD_MODE_WRITE, CMD_CAL, CMD_READ, CMD_WRITE} cmd_t;

  typedef struct packed {
    logic resetN;
    logic cmdClk;
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic termination_control_input;
    logic [2:0] bankSelect;
    logic [12:0] addr;
  } pins_t;

  typedef struct packed {
    logic [1:0] burstLength;
    logic interleaved;
    logic lastChop;
    logic dllResetSeen;
    logic dllEnabled;
    logic calStarted;
    logic ready;
    logic [3:0] written;
    logic ckeEarly;
    logic ckeSeen;
    logic [2:0] state;
  } status_t;
endpackage : ddr_init_pkg

// >>> hw/mode_reg_store.sv
// Four-word store holding the mode register images.
// Assumes writer and reader share clk; read data appear one cycle after rdAddr.
`timescale 1ns/100ps
module mode_reg_store (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [1:0] wrAddr,
  input wire logic [12:0] wrData,
  input wire logic [1:0] rdAddr,
  output logic [12:0] rdData
);
  logic [12:0] mem [4];

  // No reset: contents stay undefined until written, as in the device
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : mode_reg_store

// >>> verif/ddr_init_seq_assertions.sv
// Assertions on the DRAM init block ports.
// Assumes binding to ddr_init_seq.
`timescale 1ns/100ps
module ddr_init_seq_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire ddr_init_pkg::pins_t pins,
  input wire logic termOn,
  input wire logic devReady,
  input wire logic burstInterleaved,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Long enough to pass the pin synchronisers
  sequence dramLow;
    !pins.resetN [*8];
  endsequence
  sequence modeZero(b);
    $rose(pins.cmdClk) && pins.cke && {pins.csN, pins.rasN, pins.casN, pins.weN} == 4'h0
      && pins.bankSelect == 3'h0 && pins.addr[3] == b;
  endsequence
  a_term_reset: assert property (dramLow |-> !termOn) else $error("term on in reset");
  a_ready_reset: assert property (dramLow |-> !devReady) else $error("ready in reset");
  a_init_quiet: assert property (dramLow ##1 pins.resetN |-> !termOn [*8])
    else $error("term on in init");
  a_mr0_inter: assert property (modeZero(1'b1) |-> ##[1:10] burstInterleaved)
    else $error("interleave not set");
  a_mr0_seq: assert property (modeZero(1'b0) |-> ##[1:10] !burstInterleaved)
    else $error("interleave not cleared");
  a_b_once: assert property (bvalid && bready |=> !bvalid) else $error("double bresp");
  a_r_once: assert property (rvalid && rready |=> !rvalid) else $error("double rresp");
  a_aw_busy: assert property (bvalid |-> !awready) else $error("aw taken while busy");
endmodule : ddr_init_seq_assertions
bind ddr_init_seq ddr_init_seq_assertions ddr_init_seq_assertions_i (.clk(clk),
  .resetn(resetn), .pins(pins), .termOn(termOn), .devReady(devReady),
  .burstInterleaved(burstInterleaved), .awready(awready), .bvalid(bvalid),
  .bready(bready), .rvalid(rvalid), .rready(rready));

// >>> verif/dram_ctrl_model.sv
// Memory controller model driving the DRAM-side pins.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
module dram_ctrl_model #(
  parameter int INIT_CYCLES = 20
) (
  input wire logic clk,
  output ddr_init_pkg::pins_t pins
);
  ddr_init_pkg::pins_t drv = 24'h1e0000;
  logic cmdClk = 1'b0;
  logic run = 1'b0;
  initial begin
    #37;
    forever #100 cmdClk = run & ~cmdClk;
  end
  always_comb begin
    pins = drv;
    pins.cmdClk = cmdClk;
  end
  // Changes land half a command clock away from the sampling edge
  task automatic edges(input int n);
    repeat (n) @(negedge cmdClk);
    @(posedge clk);
  endtask : edges
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    edges(1);
    {drv.csN, drv.rasN, drv.casN, drv.weN, drv.bankSelect, drv.addr} <= {c, b, a};
    edges(1);
    drv.csN <= 1'b1;
    {drv.rasN, drv.casN, drv.weN, drv.bankSelect, drv.addr} <= 19'($urandom);
    edges(3);
  endtask : issue
  task automatic init(input int hold, input logic [12:0] mr [4]);
    int ord [4] = '{2, 3, 1, 0};
    drv.cke <= 1'b0;
    drv.resetN <= 1'b0;
    repeat (hold) @(posedge clk);
    drv.resetN <= 1'b1;
    drv.termination_control_input <= 1'b1;
    repeat (INIT_CYCLES + 4) @(posedge clk);
    run <= 1'b1;
    edges(6);
    drv.cke <= 1'b1;
    edges(6);
    for (int i = 0; i < 4; i++) issue(4'h0, 3'(ord[i]), mr[ord[i]]);
    issue(4'h6, 3'h0, 13'h0400);
  endtask : init
endmodule : dram_ctrl_model

// >>> verif/ddr_init_seq_bench.sv
// Bench for the DRAM init block: register bus, init runs, burst modes.
// Assumes the controller model alone drives the DRAM-side pins.
`timescale 1ns/100ps
module ddr_init_seq_bench;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, termOn, devReady, burstInterleaved, burstChop, b;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  logic [33:0] e;
  logic [12:0] mr [4];
  // Length code, chop select, chop expected
  logic [3:0] cs [4] = '{4'h5, 4'h6, 4'hb, 4'h0};
  ddr_init_pkg::pins_t pins;
  int bad_count = 0;
  int compares = 0;
  int n;
  dram_ctrl_model #(.INIT_CYCLES(20)) dram_ctrl_model_i (.clk(clk), .pins(pins));
  ddr_init_seq #(.INIT_CYCLES(20)) ddr_init_seq_i (.clk(clk), .resetn(resetn), .pins(pins),
    .termOn(termOn), .devReady(devReady), .burstInterleaved(burstInterleaved),
    .burstChop(burstChop), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("Checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    if (rvalid && rready) begin
      e = rq.pop_front();
      check("rdata", rdata, e[33:2]);
      check("rresp", 32'(rresp), 32'(e[1:0]));
    end
    if (bvalid && bready) begin
      check("bresp", 32'(bresp), 32'(bq.pop_front()));
    end
  end
  task automatic axi(input bit wr, input logic [4:0] a, input logic [31:0] d,
    input logic [33:0] x);
    bit done;
    done = 1'b0;
    if (wr) bq.push_back(x[1:0]);
    else rq.push_back(x);
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= {3{wr}};
    {arvalid, rready} <= {2{!wr}};
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      done = wr ? bvalid : rvalid;
    end
    {bready, rready} <= 2'h0;
    if (!done) begin
      bad_count++;
      final_report();
    end
  endtask : axi
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 42'h0;
    void'($urandom(32'hfb152080));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    axi(0, 5'h04, 0, 34'h0);
    axi(0, 5'h0c, 0, 34'h2);
    axi(1, 5'h0c, 1, 34'h2);
    for (int i = 0; i < 4; i++) axi(0, 5'(16 + 4 * i), 0, 34'h0);
    $display("Test reset values done");
    mr[0] = (13'($urandom) & 13'h1e74) | 13'h0109;
    // Nominal termination kept off so a high termination input is legal
    mr[1] = 13'($urandom) & 13'h1dba;
    mr[2] = 13'($urandom);
    mr[3] = 13'($urandom);
    for (int k = 0; k < 2; k++) begin
      dram_ctrl_model_i.init((k == 0) ? 8000 : 10, mr);
      check("early ready", 32'(devReady), 0);
      for (n = 0; n < 6000 && devReady !== 1'b1; n++) @(posedge clk);
      check("ready", 32'(devReady), 1);
      if (n == 6000) final_report();
      check("termination", 32'(termOn), 1);
      axi(0, 5'h04, 0, {32'hdfec, 2'h0});
      for (int i = 1; i < 4; i++) axi(0, 5'(16 + 4 * i), 0, {19'h0, mr[i], 2'h0});
      $display("Test init run %0d done", k);
    end
    for (int j = 0; j < 4; j++) begin
      b = 1'($urandom);
      dram_ctrl_model_i.issue(4'h0, 3'h0, {9'h0, b, 1'b0, cs[j][3:2]});
      dram_ctrl_model_i.issue(4'h5, 3'h0, {cs[j][1], 12'h0});
      axi(0, 5'h08, 0, {30'h0, b, cs[j][0], 2'h0});
    end
    $display("Test burst modes done");
    axi(1, 5'h00, 1, 34'h0);
    axi(0, 5'h00, 0, {32'h1, 2'h0});
    check("forced off", 32'(termOn), 0);
    axi(1, 5'h00, 0, 34'h0);
    $display("Test termination control done");
    final_report();
  end
endmodule : ddr_init_seq_bench
